//--- inc/tcc_pkg.sv
// Package of register map, field layout and encodings for the timer 4 compare channels
package tcc_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [9:0] IDX_FLAGS = 10'h0D8;
  localparam logic [9:0] IDX_CH0_CTL = 10'h0EC;
  localparam logic [9:0] IDX_CH0_VAL = 10'h0ED;
  localparam logic [9:0] IDX_CH1_CTL = 10'h0EE;
  localparam logic [9:0] IDX_CH1_VAL = 10'h0EF;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0F0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0F1;

  // Address slicing of the bus
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 11;
  localparam logic [19:0] ADDR_HI_ZERO = 20'h00000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // Register widths
  localparam int REG_W = 8;
  localparam int CTL_W = 7;
  localparam logic [23:0] RDATA_PAD = 24'h000000;

  // Channel compare control fields
  localparam int CTL_IM = 6;
  localparam int CTL_ACT_MSB = 5;
  localparam int CTL_ACT_LSB = 3;
  localparam int CTL_EN = 2;
  localparam logic [6:0] CTL_RESET = 7'h40;
  localparam logic [7:0] VAL_RESET = 8'h00;

  // Shared flag register fields
  localparam int FLG_WIDE_TIMER_OVERFLOW_MASK = 6;
  localparam int FLG_T_B_CH1_PENDING = 5;
  localparam int FLG_T_B_CH0_PENDING = 4;
  localparam int FLG_T_B_OVERFLOW_PENDING = 3;
  localparam int FLG_T_A_CH1_PENDING = 2;
  localparam int FLG_T_A_CH0_PENDING = 1;
  localparam int FLG_T_A_OVERFLOW_PENDING = 0;
  localparam logic [6:0] FLG_RESET = 7'h40;

  // Interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_CH0 = 0;
  localparam int IRQ_CH1 = 1;
  localparam int IRQ_OVF = 2;
  localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Count values used by the output actions
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CH0_ALT_CLR = 8'hFF;
  localparam logic [7:0] CH0_ALT_SET = 8'h00;
  localparam logic PIN_RESET = 1'b0;

  // Output action codes
  typedef enum logic [2:0] {
    ACT_SET = 3'h0,
    ACT_CLR = 3'h1,
    ACT_TOGGLE = 3'h2,
    ACT_SET_UP = 3'h3,
    ACT_CLR_UP = 3'h4,
    ACT_SET_ALT = 3'h5,
    ACT_CLR_ALT = 3'h6,
    ACT_UNUSED = 3'h7
  } tcc_action_t;

endpackage

//--- rtl/tcc_compare_chan.sv
// One compare channel: match detection and output action
`timescale 1ns/10ps
`default_nettype none
module tcc_compare_chan
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Channel configuration
  input wire logic chanEnable,
  input wire logic [2:0] actionSel,
  input wire logic [7:0] cmpValue,
  input wire logic [7:0] altClrValue,
  input wire logic [7:0] altSetValue,
  // Counter status
  input wire logic cntTick,
  input wire logic [7:0] cntValue,
  input wire logic upDownMode,
  input wire logic cntDown,
  // Results
  output logic matchHit,
  output logic pinOut
);

  logic pinOut_ff;
  logic nxt_pinOut;
  logic atZero;
  logic atAltClr;
  logic atAltSet;
  tcc_action_t act;

  // Events qualified by the enable and the counter update
  assign act = tcc_action_t'(actionSel);
  assign matchHit = chanEnable && cntTick && (cntValue == cmpValue);
  assign atZero = chanEnable && cntTick && (cntValue == CNT_ZERO);
  assign atAltClr = chanEnable && cntTick && (cntValue == altClrValue);
  assign atAltSet = chanEnable && cntTick && (cntValue == altSetValue);

  // Output action; the match wins when both values coincide
  always_comb begin
    nxt_pinOut = pinOut_ff;
    unique case (act)
      ACT_SET: if (matchHit) nxt_pinOut = 1'b1;
      ACT_CLR: if (matchHit) nxt_pinOut = 1'b0;
      ACT_TOGGLE: if (matchHit) nxt_pinOut = !pinOut_ff;
      ACT_SET_UP: begin
        if (upDownMode) begin
          if (matchHit) nxt_pinOut = !cntDown;
        end else if (matchHit) begin
          nxt_pinOut = 1'b1;
        end else if (atZero) begin
          nxt_pinOut = 1'b0;
        end
      end
      ACT_CLR_UP: begin
        if (upDownMode) begin
          if (matchHit) nxt_pinOut = cntDown;
        end else if (matchHit) begin
          nxt_pinOut = 1'b0;
        end else if (atZero) begin
          nxt_pinOut = 1'b1;
        end
      end
      ACT_SET_ALT: begin
        if (matchHit) nxt_pinOut = 1'b1;
        else if (atAltClr) nxt_pinOut = 1'b0;
      end
      ACT_CLR_ALT: begin
        if (matchHit) nxt_pinOut = 1'b0;
        else if (atAltSet) nxt_pinOut = 1'b1;
      end
      ACT_UNUSED: nxt_pinOut = pinOut_ff; // Reserved code holds the pin
    endcase
  end

  // Pin register
  always_ff @(posedge clk) begin
    if (srst) pinOut_ff <= PIN_RESET;
    else pinOut_ff <= nxt_pinOut;
  end

  assign pinOut = pinOut_ff;

  a_set_on_match: assert property (@(posedge clk) disable iff (srst)
    matchHit && act == ACT_SET |=> pinOut_ff) else $error("set on match missed");
  a_clr_on_match: assert property (@(posedge clk) disable iff (srst)
    matchHit && act == ACT_CLR |=> !pinOut_ff) else $error("clear on match missed");
  a_toggle_match: assert property (@(posedge clk) disable iff (srst)
    matchHit && act == ACT_TOGGLE |=> pinOut_ff != $past(pinOut_ff)) else $error("toggle missed");
  a_down_clears: assert property (@(posedge clk) disable iff (srst)
    matchHit && act == ACT_SET_UP && upDownMode && cntDown |=> !pinOut_ff) else $error("down match not clear");
  a_alt_clears: assert property (@(posedge clk) disable iff (srst)
    atAltClr && !matchHit && act == ACT_SET_ALT |=> !pinOut_ff) else $error("alt clear missed");

endmodule
`default_nettype wire

//--- rtl/tcc_timer4_compare.sv
// Timer 4 compare channels, shared timer flag register and AHB-Lite register slave
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module tcc_timer4_compare
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer 4 counter core
  input wire logic cntTick,
  input wire logic [7:0] cntValue,
  input wire logic cntUpDown,
  input wire logic cntDown,
  input wire logic tBOverflowEvent,
  // Second 8-bit timer events
  input wire logic tACh0Event,
  input wire logic tACh1Event,
  input wire logic tAOverflowEvent,
  // Outputs
  output logic ch0Out,
  output logic ch1Out,
  output logic wideTimerOverflowMask,
  output logic irq
);

  // Hardware set wins over a software clear in the same cycle
  function automatic logic flagNext(input logic cur, input logic clr, input logic set);
    flagNext = set | (cur & !clr);
  endfunction

  logic [9:0] addr_ff;
  logic [9:0] nxt_addr;
  logic wrPend_ff;
  logic nxt_wrPend;
  logic rdPend_ff;
  logic nxt_rdPend;
  logic hreadyout_ff;
  logic nxt_hreadyout;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic addrPhase;
  logic addrHit;
  logic [7:0] rdByte;

  logic [7:0] ch0CompareValue_ff;
  logic [7:0] nxt_ch0CompareValue;
  logic [7:0] ch1CompareValue_ff;
  logic [7:0] nxt_ch1CompareValue;
  logic [6:0] ch0CompareControl_ff;
  logic [6:0] nxt_ch0CompareControl;
  logic [6:0] ch1CompareControl_ff;
  logic [6:0] nxt_ch1CompareControl;
  logic [6:0] timerFlagRegister_ff;
  logic [6:0] nxt_timerFlagRegister;
  logic [2:0] irqStatus_ff;
  logic [2:0] nxt_irqStatus;
  logic [2:0] irqMask_ff;
  logic [2:0] nxt_irqMask;
  logic irq_ff;
  logic nxt_irq;
  logic [2:0] irqGate;

  logic wrFlags;
  logic wrStatus;
  logic ch0Match;
  logic ch1Match;
  logic ch0Pin;
  logic ch1Pin;

  // Only whole-word transfers inside the low 4 KB window are accepted
  assign addrPhase = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
  assign addrHit = addrPhase && (hsize == HSIZE_WORD) && (haddr[31:12] == ADDR_HI_ZERO);

  // Register read mux; unmapped words and reserved top bits read zero
  always_comb begin
    rdByte = 8'h00;
    unique case (addr_ff)
      IDX_FLAGS: rdByte = {1'b0, timerFlagRegister_ff};
      IDX_CH0_CTL: rdByte = {1'b0, ch0CompareControl_ff};
      IDX_CH0_VAL: rdByte = ch0CompareValue_ff;
      IDX_CH1_CTL: rdByte = {1'b0, ch1CompareControl_ff};
      IDX_CH1_VAL: rdByte = ch1CompareValue_ff;
      IDX_IRQ_STATUS: rdByte = {5'h00, irqStatus_ff};
      IDX_IRQ_MASK: rdByte = {5'h00, irqMask_ff};
      default: rdByte = 8'h00;
    endcase
  end

  // Bus phases; reads take one wait state so a preceding write is visible
  always_comb begin
    nxt_addr = addr_ff;
    nxt_wrPend = 1'b0;
    nxt_rdPend = 1'b0;
    nxt_hreadyout = 1'b1;
    nxt_hrdata = hrdata_ff;
    if (rdPend_ff) begin
      nxt_hrdata = {RDATA_PAD, rdByte};
    end else if (addrPhase) begin
      nxt_addr = addrHit ? haddr[ADDR_IDX_MSB:ADDR_IDX_LSB] : IDX_IRQ_MASK + 10'h001;
      nxt_wrPend = hwrite;
      nxt_rdPend = !hwrite;
      nxt_hreadyout = hwrite;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_ff <= 10'h000;
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
    end else begin
      addr_ff <= nxt_addr;
      wrPend_ff <= nxt_wrPend;
      rdPend_ff <= nxt_rdPend;
      hreadyout_ff <= nxt_hreadyout;
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign wrFlags = wrPend_ff && (addr_ff == IDX_FLAGS);
  assign wrStatus = wrPend_ff && (addr_ff == IDX_IRQ_STATUS);

  // Value and control registers, written in the data phase
  always_comb begin
    nxt_ch0CompareValue = ch0CompareValue_ff;
    nxt_ch1CompareValue = ch1CompareValue_ff;
    nxt_ch0CompareControl = ch0CompareControl_ff;
    nxt_ch1CompareControl = ch1CompareControl_ff;
    nxt_irqMask = irqMask_ff;
    if (wrPend_ff) begin
      unique case (addr_ff)
        IDX_CH0_VAL: nxt_ch0CompareValue = hwdata[REG_W-1:0];
        IDX_CH1_VAL: nxt_ch1CompareValue = hwdata[REG_W-1:0];
        IDX_CH0_CTL: nxt_ch0CompareControl = hwdata[CTL_W-1:0];
        IDX_CH1_CTL: nxt_ch1CompareControl = hwdata[CTL_W-1:0];
        IDX_IRQ_MASK: nxt_irqMask = hwdata[IRQ_W-1:0];
        default: nxt_irqMask = irqMask_ff;
      endcase
    end
  end

  // Interrupt mask bits reset to zero, so no channel interrupts until irqMask is written
  always_ff @(posedge clk) begin
    if (srst) begin
      ch0CompareValue_ff <= VAL_RESET;
      ch1CompareValue_ff <= VAL_RESET;
      ch0CompareControl_ff <= CTL_RESET;
      ch1CompareControl_ff <= CTL_RESET;
      irqMask_ff <= IRQ_MASK_RESET;
    end else begin
      ch0CompareValue_ff <= nxt_ch0CompareValue;
      ch1CompareValue_ff <= nxt_ch1CompareValue;
      ch0CompareControl_ff <= nxt_ch0CompareControl;
      ch1CompareControl_ff <= nxt_ch1CompareControl;
      irqMask_ff <= nxt_irqMask;
    end
  end

  // Channel 0 alternate points are the counter ends
  tcc_compare_chan u_ch0 (
    .clk(clk),
    .srst(srst),
    .chanEnable(ch0CompareControl_ff[CTL_EN]),
    .actionSel(ch0CompareControl_ff[CTL_ACT_MSB:CTL_ACT_LSB]),
    .cmpValue(ch0CompareValue_ff),
    .altClrValue(CH0_ALT_CLR),
    .altSetValue(CH0_ALT_SET),
    .cntTick(cntTick),
    .cntValue(cntValue),
    .upDownMode(cntUpDown),
    .cntDown(cntDown),
    .matchHit(ch0Match),
    .pinOut(ch0Pin)
  );

  // Channel 1 alternate point is the channel 0 compare value
  tcc_compare_chan u_ch1 (
    .clk(clk),
    .srst(srst),
    .chanEnable(ch1CompareControl_ff[CTL_EN]),
    .actionSel(ch1CompareControl_ff[CTL_ACT_MSB:CTL_ACT_LSB]),
    .cmpValue(ch1CompareValue_ff),
    .altClrValue(ch0CompareValue_ff),
    .altSetValue(ch0CompareValue_ff),
    .cntTick(cntTick),
    .cntValue(cntValue),
    .upDownMode(cntUpDown),
    .cntDown(cntDown),
    .matchHit(ch1Match),
    .pinOut(ch1Pin)
  );

  // Pending flags: zero written clears, one written is ignored
  always_comb begin
    nxt_timerFlagRegister = timerFlagRegister_ff;
    nxt_timerFlagRegister[FLG_T_B_CH1_PENDING] = flagNext(timerFlagRegister_ff[FLG_T_B_CH1_PENDING],
      wrFlags && !hwdata[FLG_T_B_CH1_PENDING], ch1Match);
    nxt_timerFlagRegister[FLG_T_B_CH0_PENDING] = flagNext(timerFlagRegister_ff[FLG_T_B_CH0_PENDING],
      wrFlags && !hwdata[FLG_T_B_CH0_PENDING], ch0Match);
    nxt_timerFlagRegister[FLG_T_B_OVERFLOW_PENDING] = flagNext(timerFlagRegister_ff[FLG_T_B_OVERFLOW_PENDING],
      wrFlags && !hwdata[FLG_T_B_OVERFLOW_PENDING], tBOverflowEvent);
    nxt_timerFlagRegister[FLG_T_A_CH1_PENDING] = flagNext(timerFlagRegister_ff[FLG_T_A_CH1_PENDING],
      wrFlags && !hwdata[FLG_T_A_CH1_PENDING], tACh1Event);
    nxt_timerFlagRegister[FLG_T_A_CH0_PENDING] = flagNext(timerFlagRegister_ff[FLG_T_A_CH0_PENDING],
      wrFlags && !hwdata[FLG_T_A_CH0_PENDING], tACh0Event);
    nxt_timerFlagRegister[FLG_T_A_OVERFLOW_PENDING] = flagNext(timerFlagRegister_ff[FLG_T_A_OVERFLOW_PENDING],
      wrFlags && !hwdata[FLG_T_A_OVERFLOW_PENDING], tAOverflowEvent);
    if (wrFlags) begin
      nxt_timerFlagRegister[FLG_WIDE_TIMER_OVERFLOW_MASK] = hwdata[FLG_WIDE_TIMER_OVERFLOW_MASK];
    end
  end

  // Sticky status is write-one-to-clear, unlike the flag register
  always_comb begin
    nxt_irqStatus[IRQ_CH0] = flagNext(irqStatus_ff[IRQ_CH0], wrStatus && hwdata[IRQ_CH0], ch0Match);
    nxt_irqStatus[IRQ_CH1] = flagNext(irqStatus_ff[IRQ_CH1], wrStatus && hwdata[IRQ_CH1], ch1Match);
    nxt_irqStatus[IRQ_OVF] = flagNext(irqStatus_ff[IRQ_OVF], wrStatus && hwdata[IRQ_OVF], tBOverflowEvent);
  end

  // Channel masks gate the request; the overflow has no channel mask here
  always_comb begin
    irqGate = 3'h0;
    irqGate[IRQ_CH0] = ch0CompareControl_ff[CTL_IM];
    irqGate[IRQ_CH1] = ch1CompareControl_ff[CTL_IM];
    irqGate[IRQ_OVF] = 1'b1;
    nxt_irq = |(irqStatus_ff & irqMask_ff & irqGate);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      timerFlagRegister_ff <= FLG_RESET;
      irqStatus_ff <= IRQ_STATUS_RESET;
      irq_ff <= 1'b0;
    end else begin
      timerFlagRegister_ff <= nxt_timerFlagRegister;
      irqStatus_ff <= nxt_irqStatus;
      irq_ff <= nxt_irq;
    end
  end

  // All outputs except hresp, which is tied to OKAY, come from registers
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = HRESP_OKAY;
  assign ch0Out = ch0Pin;
  assign ch1Out = ch1Pin;
  assign wideTimerOverflowMask = timerFlagRegister_ff[FLG_WIDE_TIMER_OVERFLOW_MASK];
  assign irq = irq_ff;

  a_ch0_val_write: assert property (@(posedge clk) disable iff (srst)
    wrPend_ff && addr_ff == IDX_CH0_VAL |=> ch0CompareValue_ff == $past(hwdata[7:0]))
    else $error("ch0 value write lost");
  a_ch1_val_write: assert property (@(posedge clk) disable iff (srst)
    wrPend_ff && addr_ff == IDX_CH1_VAL |=> ch1CompareValue_ff == $past(hwdata[7:0]))
    else $error("ch1 value write lost");
  a_ch1_disabled: assert property (@(posedge clk) disable iff (srst)
    !ch1CompareControl_ff[CTL_EN] |-> !ch1Match) else $error("disabled channel matched");
  a_irq_gated: assert property (@(posedge clk) disable iff (srst)
    irq_ff |-> $past(|(irqStatus_ff & irqMask_ff & irqGate))) else $error("irq without unmasked status");
  a_ch1_flag_set: assert property (@(posedge clk) disable iff (srst)
    ch1Match |=> timerFlagRegister_ff[FLG_T_B_CH1_PENDING]) else $error("ch1 flag not set");
  a_ovf_one_ignored: assert property (@(posedge clk) disable iff (srst)
    wrFlags && hwdata[FLG_T_B_OVERFLOW_PENDING] && !timerFlagRegister_ff[FLG_T_B_OVERFLOW_PENDING]
    && !tBOverflowEvent |=> !timerFlagRegister_ff[FLG_T_B_OVERFLOW_PENDING]) else $error("flag set by write");
  a_ta_zero_clears: assert property (@(posedge clk) disable iff (srst)
    wrFlags && !hwdata[FLG_T_A_OVERFLOW_PENDING] && !tAOverflowEvent
    |=> !timerFlagRegister_ff[FLG_T_A_OVERFLOW_PENDING]) else $error("zero write did not clear");
  a_top_bit_zero: assert property (@(posedge clk) disable iff (srst)
    rdPend_ff && (addr_ff == IDX_FLAGS || addr_ff == IDX_CH1_CTL) |=> !hrdata_ff[7])
    else $error("reserved bit 7 read as one");
  a_read_wait: assert property (@(posedge clk) disable iff (srst)
    addrPhase && !hwrite && !rdPend_ff |=> !hreadyout_ff ##1 hreadyout_ff) else $error("read wait wrong");

endmodule
`default_nettype wire

//--- sim/timer4_compare_channels_test.sv
// Self-checking testbench of the timer 4 compare channels
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module timer4_compare_channels_test;
  import tcc_pkg::*;
  logic clk, srst, hsel, hwrite, hreadyout, hresp, cntTick, cntUpDown, cntDown;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] cntValue;
  logic tBOverflowEvent, tACh0Event, tACh1Event, tAOverflowEvent;
  logic ch0Out, ch1Out, wideTimerOverflowMask, irq;
  int n_errors = 0;
  int check_count = 0;
  // Mode table: code, up/down, count, down, expected ch1 pin
  logic [23:0] modeTbl [18] = '{24'h002001, 24'h102000, 24'h202001, 24'h202000, 24'h302001,
    24'h300000, 24'h400001, 24'h402000, 24'h312001, 24'h312010, 24'h502001, 24'h505A00,
    24'h605A01, 24'h702001, 24'h412000, 24'h412011, 24'h602000, 24'h702000};

  tcc_timer4_compare tcc_timer4_compare_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cntTick(cntTick),
    .cntValue(cntValue), .cntUpDown(cntUpDown), .cntDown(cntDown),
    .tBOverflowEvent(tBOverflowEvent), .tACh0Event(tACh0Event), .tACh1Event(tACh1Event),
    .tAOverflowEvent(tAOverflowEvent), .ch0Out(ch0Out), .ch1Out(ch1Out),
    .wideTimerOverflowMask(wideTimerOverflowMask), .irq(irq));

  // Clock, 4 ns period
  always #2 clk = ~clk;

  // Byte address of a register index
  function automatic logic [31:0] ba(input logic [9:0] i);
    return {20'h00000, i, 2'h0};
  endfunction

  // One AHB-Lite single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h000000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    bus(1'b1, ba(i), d);
  endtask

  task automatic rdchk(input logic [9:0] i, input logic [7:0] e);
    bus(1'b0, ba(i), 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask

  // Present one count value to the channels, then let the result settle
  task automatic tick(input logic [7:0] v, input logic ud, input logic dn);
    @(posedge clk);
    cntTick <= 1'b1;
    cntValue <= v;
    cntUpDown <= ud;
    cntDown <= dn;
    @(posedge clk);
    cntTick <= 1'b0;
    @(negedge clk);
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  // Reset values, value registers, unused control bit and unmapped place
  task automatic t_regs();
    `CHK(wideTimerOverflowMask, 1'b1)
    `CHK({ch0Out, ch1Out, irq}, 3'h0)
    rdchk(IDX_CH0_VAL, 8'h00);
    rdchk(IDX_CH1_VAL, 8'h00);
    rdchk(IDX_CH1_CTL, 8'h40);
    rdchk(IDX_FLAGS, 8'h40);
    bus(1'b1, 32'h00000100, 8'hFF);
    bus(1'b0, 32'h00000100, 8'h00);
    `CHK(rd, 32'h00000000)
    wr(IDX_CH0_VAL, 8'h5A);
    wr(IDX_CH1_VAL, 8'h20);
    rdchk(IDX_CH0_VAL, 8'h5A);
    rdchk(IDX_CH1_VAL, 8'h20);
    wr(IDX_CH1_CTL, 8'hFC);
    rdchk(IDX_CH1_CTL, 8'h7C);
    done("regs");
  endtask

  // Disabled channel ignores a match; enabled one sets pin and flag
  task automatic t_enable();
    wr(IDX_CH1_CTL, 8'h40);
    tick(8'h20, 1'b0, 1'b0);
    `CHK(ch1Out, 1'b0)
    rdchk(IDX_FLAGS, 8'h40);
    wr(IDX_CH1_CTL, 8'h44);
    tick(8'h21, 1'b0, 1'b0);
    `CHK(ch1Out, 1'b0)
    tick(8'h20, 1'b0, 1'b0);
    `CHK(ch1Out, 1'b1)
    rdchk(IDX_FLAGS, 8'h60);
    wr(IDX_CH0_CTL, 8'h44);
    tick(8'h5A, 1'b0, 1'b0);
    `CHK(ch0Out, 1'b1)
    rdchk(IDX_FLAGS, 8'h70);
    wr(IDX_CH0_CTL, 8'h6C);
    tick(8'hFF, 1'b0, 1'b0);
    `CHK(ch0Out, 1'b0)
    wr(IDX_CH0_CTL, 8'h74);
    tick(8'h00, 1'b0, 1'b0);
    `CHK(ch0Out, 1'b1)
    wr(IDX_CH0_CTL, 8'h40);
    done("enable");
  endtask

  // Every output action code, table driven
  task automatic t_modes();
    logic [23:0] e;
    for (int k = 0; k < 18; k++) begin
      e = modeTbl[k];
      wr(IDX_CH1_CTL, {2'h1, e[22:20], 3'h4});
      tick(e[15:8], e[16], e[4]);
      `CHK(ch1Out, e[0])
    end
    done("modes");
  endtask

  // Pending flags: write one ignored, write zero clears; mask bit drives its output
  task automatic t_flags();
    wr(IDX_FLAGS, 8'h40);
    @(posedge clk);
    tBOverflowEvent <= 1'b1;
    tACh0Event <= 1'b1;
    tACh1Event <= 1'b1;
    tAOverflowEvent <= 1'b1;
    @(posedge clk);
    {tBOverflowEvent, tACh0Event, tACh1Event, tAOverflowEvent} <= 4'h0;
    rdchk(IDX_FLAGS, 8'h4F);
    wr(IDX_FLAGS, 8'h7F);
    rdchk(IDX_FLAGS, 8'h4F);
    wr(IDX_FLAGS, 8'h00);
    rdchk(IDX_FLAGS, 8'h00);
    `CHK(wideTimerOverflowMask, 1'b0)
    wr(IDX_FLAGS, 8'h48);
    @(negedge clk);
    `CHK(wideTimerOverflowMask, 1'b1)
    rdchk(IDX_FLAGS, 8'h40);
    done("flags");
  endtask

  // Interrupt raised by unmasked match, cleared by write one, gated by channel mask
  task automatic t_irq();
    wr(IDX_CH1_CTL, 8'h44);
    wr(IDX_IRQ_STATUS, 8'h07);
    tick(8'h20, 1'b0, 1'b0);
    @(negedge clk);
    `CHK(irq, 1'b0)
    rdchk(IDX_IRQ_STATUS, 8'h02);
    wr(IDX_IRQ_MASK, 8'h02);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wr(IDX_CH1_CTL, 8'h04);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    wr(IDX_CH1_CTL, 8'h44);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_STATUS, 8'h02);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    done("irq");
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence after 16 cycles of reset
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {hsel, hwrite, cntTick, cntUpDown, cntDown} = 5'h00;
    {tBOverflowEvent, tACh0Event, tACh1Event, tAOverflowEvent} = 4'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    cntValue = 8'h00;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    t_regs();
    t_enable();
    t_modes();
    t_flags();
    t_irq();
    conclude();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
